/* crtc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the calendar RTC.
// Assumes inclusion by bare name from the package file and the calendar and top modules.
`ifndef CRTC_DEFS_SVH
`define CRTC_DEFS_SVH

// ****************************************************************
// Register byte offsets (Avalon-MM byte addresses)
// ****************************************************************
`define CRTC_OFS_DIVISOR      6'h00
`define CRTC_OFS_DATE_PRESET  6'h04
`define CRTC_OFS_CLOCK_PRESET 6'h08
`define CRTC_OFS_CTRL         6'h0c
`define CRTC_OFS_ALARM_SETUP0 6'h10
`define CRTC_OFS_ALARM_SETUP1 6'h14
`define CRTC_OFS_LIVE_DATE    6'h18
`define CRTC_OFS_LIVE_CLOCK   6'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define CRTC_DIV_MSB          15
`define CRTC_YEAR_MSB         23
`define CRTC_YEAR_LSB         12
`define CRTC_MONTH_MSB        11
`define CRTC_MONTH_LSB        8
`define CRTC_DAY_MSB          4
`define CRTC_DAY_LSB          0
`define CRTC_WDAY_MSB         26
`define CRTC_WDAY_LSB         24
`define CRTC_HOUR_MSB         20
`define CRTC_HOUR_LSB         16
`define CRTC_MIN_MSB          13
`define CRTC_MIN_LSB          8
`define CRTC_SEC_MSB          5
`define CRTC_SEC_LSB          0
`define CRTC_CTRL_ENABLE      0
`define CRTC_CTRL_RUNNING     1
`define CRTC_CTRL_LOAD        4
`define CRTC_CTRL_LEAP_SUPP   8
`define CRTC_AL0_GLOBAL_EN    28
`define CRTC_AL0_YEAR_EN      26
`define CRTC_AL0_MONTH_EN     25
`define CRTC_AL0_DAY_EN       24
`define CRTC_AL1_WDAY_EN      31
`define CRTC_AL1_HOUR_EN      30
`define CRTC_AL1_MIN_EN       29
`define CRTC_AL1_SEC_EN       28

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define CRTC_RST_WORD         32'h0000_0000
`define CRTC_RST_DIVISOR      16'h0000
`define CRTC_CDC_REF_EDGES    2'h2
`define CRTC_LAST_SEC         6'h3b
`define CRTC_LAST_MIN         6'h3b
`define CRTC_LAST_HOUR        5'h17
`define CRTC_LAST_WDAY        3'h6
`define CRTC_LAST_MONTH       4'hc
`define CRTC_FEB              4'h2

`endif

/* crtc_pkg.sv */
// Types shared by the calendar RTC modules.
// Assumes crtc_defs.svh is on the include path.
`include "crtc_defs.svh"

package crtc_pkg;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [2:0]  wday;
    logic [4:0]  hour;
    logic [5:0]  min;
    logic [5:0]  sec;
  } crtc_time_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } crtc_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } crtc_avs_rsp_t;

  typedef struct packed {
    logic        enable;
    logic        leapSuppress;
    logic [15:0] divisor;
    logic [31:0] alarm0;
    logic [31:0] alarm1;
  } crtc_cfg_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } crtc_sync_state_t;

endpackage : crtc_pkg

/* crtc_sync.sv */
// Two-flop synchroniser for one level from outside the clk_sys domain.
// Assumes the input is a plain level; only the second stage is visible.
`timescale 1ns/10ps
`default_nettype none

module crtc_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  import crtc_pkg::*;

  crtc_sync_state_t s_q;
  crtc_sync_state_t s_d;

  always_comb begin
    s_d.stage1 = asyncIn;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign syncOut = s_q.stage2;

endmodule : crtc_sync

`default_nettype wire

/* crtc_calendar.sv */
// Combinational one-second advance of the seven calendar fields.
// Assumes legal field values; no range checking is done.
`timescale 1ns/10ps
`default_nettype none
`include "crtc_defs.svh"

module crtc_calendar (
  input  wire crtc_pkg::crtc_time_t cur,
  input  wire logic                 leapSuppress,
  output crtc_pkg::crtc_time_t      nxt
);
  import crtc_pkg::*;

  logic [4:0] monthLen;

  always_comb begin
    // Leap decision only matters at the Feb 28 and Feb 29 day rollovers
    case (cur.month)
      `CRTC_FEB: begin
        monthLen = (!leapSuppress && cur.year[1:0] == 2'b00) ? 5'd29 : 5'd28;
      end
      4'h4, 4'h6, 4'h9, 4'hb: begin
        monthLen = 5'd30;
      end
      default: begin
        monthLen = 5'd31;
      end
    endcase
  end

  always_comb begin
    nxt = cur;
    if (cur.sec != `CRTC_LAST_SEC) begin
      nxt.sec = cur.sec + 6'h01;
    end else begin
      nxt.sec = 6'h00;
      if (cur.min != `CRTC_LAST_MIN) begin
        nxt.min = cur.min + 6'h01;
      end else begin
        nxt.min = 6'h00;
        if (cur.hour != `CRTC_LAST_HOUR) begin
          nxt.hour = cur.hour + 5'h01;
        end else begin
          nxt.hour = 5'h00;
          // Weekday just steps; never derived from the date
          nxt.wday = (cur.wday == `CRTC_LAST_WDAY) ? 3'h0 : cur.wday + 3'h1;
          if (cur.day != monthLen) begin
            nxt.day = cur.day + 5'h01;
          end else begin
            nxt.day = 5'h01;
            if (cur.month != `CRTC_LAST_MONTH) begin
              nxt.month = cur.month + 4'h1;
            end else begin
              nxt.month = 4'h1;
              nxt.year  = cur.year + 12'h001;
            end
          end
        end
      end
    end
  end

endmodule : crtc_calendar

`default_nettype wire

/* crtc_top.sv */
// Calendar real-time clock with alarm, Avalon-MM register slave on clk_sys.
// Assumes refClk is a slow reference (1 Hz .. 65536 Hz) far below clk_sys.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "crtc_defs.svh"

module crtc_top (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    refClk,
  input  wire crtc_pkg::crtc_avs_req_t avsReq,
  output crtc_pkg::crtc_avs_rsp_t      avsRsp,
  output logic                         rtcRunning,
  output logic                         alarmToCpu,
  output logic                         alarmWakeRingOsc,
  output logic                         alarmWakeCrystalOsc
);
  import crtc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    crtc_cfg_t   sysCfg;
    logic [31:0] datePreset;
    logic [31:0] clockPreset;
    logic        loadPend;
    logic [1:0]  pendCnt;
    crtc_cfg_t   refCfg;
    crtc_time_t  now;
    logic [15:0] divCnt;
    logic [31:0] dateLatch;
    logic        ack;
    logic [31:0] rdata;
    logic        alarm;
    logic        refPrev;
  } crtc_top_state_t;

  crtc_top_state_t s_q;
  crtc_top_state_t s_d;

  logic       refSync;
  logic       refEdge;
  logic       req;
  logic       accept;
  crtc_time_t nextTime;
  logic       fieldMatch;
  logic [31:0] liveDate;
  logic [31:0] liveClock;

  // ****************************************************************
  // Reference clock sampling
  // ****************************************************************
  // Reference is slow, so it is sampled as a level rather than
  // given its own domain; each rising edge is one reference period.
  crtc_sync u_refSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .asyncIn (refClk),
    .syncOut (refSync)
  );

  assign refEdge = refSync & ~s_q.refPrev;

  crtc_calendar u_calendar (
    .cur          (s_q.now),
    .leapSuppress (s_q.refCfg.leapSuppress),
    .nxt          (nextTime)
  );

  // ****************************************************************
  // Live words and alarm compare
  // ****************************************************************
  always_comb begin
    liveDate = `CRTC_RST_WORD;
    liveDate[`CRTC_YEAR_MSB:`CRTC_YEAR_LSB]   = s_q.now.year;
    liveDate[`CRTC_MONTH_MSB:`CRTC_MONTH_LSB] = s_q.now.month;
    liveDate[`CRTC_DAY_MSB:`CRTC_DAY_LSB]     = s_q.now.day;
    liveClock = `CRTC_RST_WORD;
    liveClock[`CRTC_WDAY_MSB:`CRTC_WDAY_LSB]  = s_q.now.wday;
    liveClock[`CRTC_HOUR_MSB:`CRTC_HOUR_LSB]  = s_q.now.hour;
    liveClock[`CRTC_MIN_MSB:`CRTC_MIN_LSB]    = s_q.now.min;
    liveClock[`CRTC_SEC_MSB:`CRTC_SEC_LSB]    = s_q.now.sec;
  end

  always_comb begin
    fieldMatch = 1'b1;
    if (s_q.refCfg.alarm0[`CRTC_AL0_YEAR_EN] &&
        s_q.refCfg.alarm0[`CRTC_YEAR_MSB:`CRTC_YEAR_LSB] != s_q.now.year) begin
      fieldMatch = 1'b0;
    end
    if (s_q.refCfg.alarm0[`CRTC_AL0_MONTH_EN] &&
        s_q.refCfg.alarm0[`CRTC_MONTH_MSB:`CRTC_MONTH_LSB] != s_q.now.month) begin
      fieldMatch = 1'b0;
    end
    if (s_q.refCfg.alarm0[`CRTC_AL0_DAY_EN] &&
        s_q.refCfg.alarm0[`CRTC_DAY_MSB:`CRTC_DAY_LSB] != s_q.now.day) begin
      fieldMatch = 1'b0;
    end
    if (s_q.refCfg.alarm1[`CRTC_AL1_WDAY_EN] &&
        s_q.refCfg.alarm1[`CRTC_WDAY_MSB:`CRTC_WDAY_LSB] != s_q.now.wday) begin
      fieldMatch = 1'b0;
    end
    if (s_q.refCfg.alarm1[`CRTC_AL1_HOUR_EN] &&
        s_q.refCfg.alarm1[`CRTC_HOUR_MSB:`CRTC_HOUR_LSB] != s_q.now.hour) begin
      fieldMatch = 1'b0;
    end
    if (s_q.refCfg.alarm1[`CRTC_AL1_MIN_EN] &&
        s_q.refCfg.alarm1[`CRTC_MIN_MSB:`CRTC_MIN_LSB] != s_q.now.min) begin
      fieldMatch = 1'b0;
    end
    if (s_q.refCfg.alarm1[`CRTC_AL1_SEC_EN] &&
        s_q.refCfg.alarm1[`CRTC_SEC_MSB:`CRTC_SEC_LSB] != s_q.now.sec) begin
      fieldMatch = 1'b0;
    end
  end

  // ****************************************************************
  // Byte-lane merge for writes
  // ****************************************************************
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign req    = avsReq.read | avsReq.write;
  assign accept = req & s_q.ack;

  always_comb begin
    logic [31:0] ctrlWord;
    logic [31:0] merged;
    ctrlWord = `CRTC_RST_WORD;
    merged   = `CRTC_RST_WORD;
    s_d = s_q;
    s_d.refPrev = refSync;

    // One wait cycle on every access; data registered before release
    s_d.ack = req & ~s_q.ack;

    // ****************************************
    // Register reads
    // ****************************************
    ctrlWord[`CRTC_CTRL_ENABLE]    = s_q.sysCfg.enable;
    ctrlWord[`CRTC_CTRL_RUNNING]   = s_q.refCfg.enable;
    ctrlWord[`CRTC_CTRL_LEAP_SUPP] = s_q.sysCfg.leapSuppress;

    if (avsReq.read && !s_q.ack) begin
      case (avsReq.address)
        `CRTC_OFS_DIVISOR: begin
          s_d.rdata = {16'h0000, s_q.sysCfg.divisor};
        end
        `CRTC_OFS_DATE_PRESET: begin
          s_d.rdata = s_q.datePreset;
        end
        `CRTC_OFS_CLOCK_PRESET: begin
          s_d.rdata = s_q.clockPreset;
        end
        `CRTC_OFS_CTRL: begin
          s_d.rdata = ctrlWord;
        end
        `CRTC_OFS_ALARM_SETUP0: begin
          s_d.rdata = s_q.sysCfg.alarm0;
        end
        `CRTC_OFS_ALARM_SETUP1: begin
          s_d.rdata = s_q.sysCfg.alarm1;
        end
        `CRTC_OFS_LIVE_DATE: begin
          s_d.rdata = s_q.dateLatch;
        end
        `CRTC_OFS_LIVE_CLOCK: begin
          s_d.rdata = liveClock;
        end
        default: begin
          s_d.rdata = `CRTC_RST_WORD;
        end
      endcase
    end

    // Date word frozen at the same edge as the clock word's read data
    if (avsReq.read && !s_q.ack && avsReq.address == `CRTC_OFS_LIVE_CLOCK) begin
      s_d.dateLatch = liveDate;
    end

    // ****************************************
    // Counting side
    // ****************************************
    // Counting side, advanced once per reference period
    if (refEdge) begin
      if (s_q.refCfg.enable) begin
        if (s_q.divCnt >= s_q.refCfg.divisor) begin
          s_d.divCnt = 16'h0000;
          s_d.now    = nextTime;
        end else begin
          s_d.divCnt = s_q.divCnt + 16'h0001;
        end
      end else begin
        s_d.divCnt = 16'h0000;
      end

      // Configuration lands after the second reference edge
      if (s_q.pendCnt != 2'h0) begin
        s_d.pendCnt = s_q.pendCnt - 2'h1;
        if (s_q.pendCnt == 2'h1) begin
          s_d.refCfg = s_q.sysCfg;
          if (s_q.loadPend) begin
            s_d.loadPend  = 1'b0;
            s_d.now.year  = s_q.datePreset[`CRTC_YEAR_MSB:`CRTC_YEAR_LSB];
            s_d.now.month = s_q.datePreset[`CRTC_MONTH_MSB:`CRTC_MONTH_LSB];
            s_d.now.day   = s_q.datePreset[`CRTC_DAY_MSB:`CRTC_DAY_LSB];
            s_d.now.wday  = s_q.clockPreset[`CRTC_WDAY_MSB:`CRTC_WDAY_LSB];
            s_d.now.hour  = s_q.clockPreset[`CRTC_HOUR_MSB:`CRTC_HOUR_LSB];
            s_d.now.min   = s_q.clockPreset[`CRTC_MIN_MSB:`CRTC_MIN_LSB];
            s_d.now.sec   = s_q.clockPreset[`CRTC_SEC_MSB:`CRTC_SEC_LSB];
          end
        end
      end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Register writes; a new divisor, control or alarm write restarts the crossing delay
    if (accept && avsReq.write) begin
      case (avsReq.address)
        `CRTC_OFS_DIVISOR: begin
          merged = laneMerge({16'h0000, s_q.sysCfg.divisor}, avsReq.writedata,
                             avsReq.byteenable);
          s_d.sysCfg.divisor = merged[`CRTC_DIV_MSB:0];
          s_d.pendCnt = `CRTC_CDC_REF_EDGES;
        end
        `CRTC_OFS_DATE_PRESET: begin
          merged = laneMerge(s_q.datePreset, avsReq.writedata, avsReq.byteenable);
          s_d.datePreset = `CRTC_RST_WORD;
          s_d.datePreset[`CRTC_YEAR_MSB:`CRTC_YEAR_LSB] =
            merged[`CRTC_YEAR_MSB:`CRTC_YEAR_LSB];
          s_d.datePreset[`CRTC_MONTH_MSB:`CRTC_MONTH_LSB] =
            merged[`CRTC_MONTH_MSB:`CRTC_MONTH_LSB];
          s_d.datePreset[`CRTC_DAY_MSB:`CRTC_DAY_LSB] = merged[`CRTC_DAY_MSB:`CRTC_DAY_LSB];
        end
        `CRTC_OFS_CLOCK_PRESET: begin
          merged = laneMerge(s_q.clockPreset, avsReq.writedata, avsReq.byteenable);
          s_d.clockPreset = `CRTC_RST_WORD;
          s_d.clockPreset[`CRTC_WDAY_MSB:`CRTC_WDAY_LSB] =
            merged[`CRTC_WDAY_MSB:`CRTC_WDAY_LSB];
          s_d.clockPreset[`CRTC_HOUR_MSB:`CRTC_HOUR_LSB] =
            merged[`CRTC_HOUR_MSB:`CRTC_HOUR_LSB];
          s_d.clockPreset[`CRTC_MIN_MSB:`CRTC_MIN_LSB] = merged[`CRTC_MIN_MSB:`CRTC_MIN_LSB];
          s_d.clockPreset[`CRTC_SEC_MSB:`CRTC_SEC_LSB] = merged[`CRTC_SEC_MSB:`CRTC_SEC_LSB];
        end
        `CRTC_OFS_CTRL: begin
          merged = laneMerge(ctrlWord, avsReq.writedata, avsReq.byteenable);
          s_d.sysCfg.enable       = merged[`CRTC_CTRL_ENABLE];
          s_d.sysCfg.leapSuppress = merged[`CRTC_CTRL_LEAP_SUPP];
          // Load request set here wins over a clear in the same cycle
          if (merged[`CRTC_CTRL_LOAD]) begin
            s_d.loadPend = 1'b1;
          end
          s_d.pendCnt = `CRTC_CDC_REF_EDGES;
        end
        `CRTC_OFS_ALARM_SETUP0: begin
          s_d.sysCfg.alarm0 = laneMerge(s_q.sysCfg.alarm0, avsReq.writedata,
                                        avsReq.byteenable);
          s_d.pendCnt = `CRTC_CDC_REF_EDGES;
        end
        `CRTC_OFS_ALARM_SETUP1: begin
          s_d.sysCfg.alarm1 = laneMerge(s_q.sysCfg.alarm1, avsReq.writedata,
                                        avsReq.byteenable);
          s_d.pendCnt = `CRTC_CDC_REF_EDGES;
        end
        default: begin
          // Read-only and unmapped words ignore writes
          merged = `CRTC_RST_WORD;
        end
      endcase
    end

    // ****************************************
    // Alarm
    // ****************************************
    // Level alarm; clears itself once the time moves off the match
    s_d.alarm = s_q.refCfg.alarm0[`CRTC_AL0_GLOBAL_EN] & fieldMatch;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avsRsp.readdata    = s_q.rdata;
  assign avsRsp.waitrequest = req & ~s_q.ack;
  assign rtcRunning         = s_q.refCfg.enable;
  assign alarmToCpu         = s_q.alarm;
  assign alarmWakeRingOsc   = s_q.alarm;
  assign alarmWakeCrystalOsc = s_q.alarm;

endmodule : crtc_top

`default_nettype wire

/* crtc_ref_src.sv */
// Reference clock source standing in for the slow clock feeding the RTC.
// Assumes clk_sys runs; the output moves only after its rising edges.
`timescale 1ns/10ps
`default_nettype none

module crtc_ref_src #(
  parameter int HALF = 10
) (
  input  wire logic clk_sys,
  output var  logic refClk
);
  int   cnt     = 0;
  logic level_q = 1'b0;

  // Integer period, slow enough for the synchroniser to see each level
  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) level_q <= ~level_q;
  end

  assign refClk = level_q;
endmodule : crtc_ref_src

`default_nettype wire

/* crtc_chk.sv */
// Concurrent checks on the ports of the calendar RTC top.
// Assumes a reference with high phases of about ten clk_sys cycles.
`timescale 1ns/10ps
`default_nettype none

module crtc_chk (
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic                    refClk,
  input wire crtc_pkg::crtc_avs_req_t avsReq,
  input wire crtc_pkg::crtc_avs_rsp_t avsRsp,
  input wire logic                    rtcRunning,
  input wire logic                    alarmToCpu,
  input wire logic                    alarmWakeRingOsc,
  input wire logic                    alarmWakeCrystalOsc
);
  import crtc_pkg::*;
  logic req;
  logic done;
  assign req  = avsReq.read | avsReq.write;
  assign done = avsReq.read & ~avsRsp.waitrequest;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****
  // Bus timing
  // ****
  a_first_wait: assert property (req && !$past(req) |-> avsRsp.waitrequest)
    else $error("no wait state on new access");
  a_one_wait: assert property (req && avsRsp.waitrequest |=> !avsRsp.waitrequest)
    else $error("access not answered after one wait");
  a_idle_ready: assert property (!req |-> !avsRsp.waitrequest)
    else $error("waitrequest while idle");
  a_rdata_hold: assert property (!avsReq.read |=> $stable(avsRsp.readdata))
    else $error("read data moved without a read");

  // ****
  // Read data layout
  // ****
  a_unmapped_zero: assert property (done && avsReq.address >= 6'h20 |->
    avsRsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_fields: assert property (done && avsReq.address == 6'h0c |->
    (avsRsp.readdata & 32'hffff_fefc) == 32'h0)
    else $error("control reserved or load bit read back");
  a_div_width: assert property (done && avsReq.address == 6'h00 |->
    avsRsp.readdata[31:16] == 16'h0)
    else $error("divisor upper bits not zero");
  a_date_fields: assert property (done && (avsReq.address == 6'h04 ||
    avsReq.address == 6'h18) |-> (avsRsp.readdata & 32'hff00_00e0) == 32'h0)
    else $error("date word reserved bits set");
  a_clock_fields: assert property (done && (avsReq.address == 6'h08 ||
    avsReq.address == 6'h1c) |-> (avsRsp.readdata & 32'hf8e0_c0c0) == 32'h0)
    else $error("clock word reserved bits set");

  // ****
  // Alarm and running flag
  // ****
  a_alarm_fanout: assert property (alarmToCpu == alarmWakeRingOsc &&
    alarmToCpu == alarmWakeCrystalOsc)
    else $error("alarm outputs disagree");
  // Running may only move a few cycles after a reference rising edge
  a_run_on_ref: assert property ($changed(rtcRunning) |->
    $past(refClk, 2) && !$past(refClk, 8))
    else $error("running changed away from a reference edge");

  c_clock_read: cover property (done && avsReq.address == 6'h1c);
  c_run_rise: cover property ($rose(rtcRunning));
  c_alarm_rise: cover property ($rose(alarmToCpu));
endmodule : crtc_chk

bind crtc_top crtc_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .refClk(refClk), .avsReq(avsReq),
  .avsRsp(avsRsp), .rtcRunning(rtcRunning), .alarmToCpu(alarmToCpu),
  .alarmWakeRingOsc(alarmWakeRingOsc), .alarmWakeCrystalOsc(alarmWakeCrystalOsc)
);

`default_nettype wire

/* testbench.sv */
// Self-checking bench for the calendar RTC: registers, calendar, alarm.
// Assumes crtc_ref_src drives the reference and crtc_chk is bound.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import crtc_pkg::*;
  logic          clk_sys;
  logic          rst_n;
  logic          refClk;
  crtc_avs_req_t avsReq;
  crtc_avs_rsp_t avsRsp;
  logic          rtcRunning;
  logic          alarmToCpu;
  logic          alarmRing;
  logic          alarmXtal;
  int            n_fail;
  int            tests_run;
  logic [31:0]   rd;
  logic [5:0]    adrs [6] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h18};
  logic [31:0]   masks [6] = '{32'h0000_ffff, 32'h00ff_ff1f, 32'h071f_3f3f,
                               32'hffff_ffff, 32'hffff_ffff, 32'h0};
  int            cy [6] = '{2024, 2023, 2100, 2024, 2024, 2024};
  int            cm [6] = '{2, 2, 2, 12, 4, 2};
  int            cd [6] = '{28, 28, 28, 31, 30, 29};
  bit            cs [6] = '{0, 0, 1, 0, 0, 0};
  logic [31:0]   al0 [3] = '{32'h1000_0000, 32'h0, 32'h1000_0000};
  logic [31:0]   al1 [3] = '{32'h5001_000a, 32'h1000_000a, 32'h0};
  int            alN [3] = '{0, 0, 1300};

  crtc_ref_src #(.HALF(10)) ref_src (.clk_sys(clk_sys), .refClk(refClk));
  crtc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .refClk(refClk), .avsReq(avsReq),
    .avsRsp(avsRsp), .rtcRunning(rtcRunning), .alarmToCpu(alarmToCpu),
    .alarmWakeRingOsc(alarmRing), .alarmWakeCrystalOsc(alarmXtal));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ****
  // Helpers
  // ****
  task automatic summarize;
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Holds the request until waitrequest is sampled low, then idles one cycle
  task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
    int i;
    avsReq <= '{read: !wr, write: wr, address: adr, writedata: wd, byteenable: 4'hf};
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (avsRsp.waitrequest !== 1'b0 && i < 50);
    if (avsRsp.waitrequest !== 1'b0) begin
      n_fail++;
      summarize();
    end
    rd = avsRsp.readdata;
    avsReq <= '0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wait_run(input logic want);
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, 6'h0c, 32'h0);
      if (rd[1] === want) break;
    end
    cmp("running", {31'h0, want}, {31'h0, rd[1]});
    cmp("running pin", {31'h0, want}, {31'h0, rtcRunning});
  endtask : wait_run

  function automatic logic [31:0] dateW(int y, int m, int d);
    return {8'h0, y[11:0], m[3:0], 3'h0, d[4:0]};
  endfunction : dateW

  function automatic logic [31:0] clkW(int w, int h, int mi, int s);
    return {5'h0, w[2:0], 3'h0, h[4:0], 2'h0, mi[5:0], 2'h0, s[5:0]};
  endfunction : clkW

  function automatic int mdays(int y, int m, bit supp);
    if (m == 2) return (y % 4 == 0 && !supp) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction : mdays

  // ****
  // Main sequence
  // ****
  initial begin
    int y, m, d, wd, n;
    logic [31:0] w, e;
    time tk [2];
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    avsReq = '0;
    void'($urandom(39));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a <= 32'h20; a += 4) begin
      bus(1'b0, a[5:0], 32'h0);
      cmp("reset word", 32'h0, rd);
    end
    repeat (3) begin
      for (int k = 0; k < 6; k++) begin
        w = $urandom;
        bus(1'b1, adrs[k], w);
        bus(1'b0, adrs[k], 32'h0);
        cmp("readback", w & masks[k], rd);
      end
    end
    bus(1'b1, 6'h0c, 32'h0000_0110);
    bus(1'b0, 6'h0c, 32'h0);
    cmp("control", 32'h0000_0100, rd);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b1, 6'h10, 32'h0);
    for (int k = 0; k < 6; k++) begin
      y = cy[k];
      m = cm[k];
      d = cd[k];
      wd = (k == 0) ? 6 : $urandom % 7;
      bus(1'b1, 6'h0c, 32'h0);
      wait_run(1'b0);
      bus(1'b1, 6'h04, dateW(y, m, d));
      bus(1'b1, 6'h08, clkW(wd, 23, 59, 59));
      bus(1'b1, 6'h0c, {23'h0, cs[k], 8'h11});
      wait_run(1'b1);
      e = clkW((wd + 1) % 7, 0, 0, 0);
      for (int i = 0; i < 400 && rd !== e; i++) bus(1'b0, 6'h1c, 32'h0);
      cmp("clock word", e, rd);
      if (d == mdays(y, m, cs[k])) begin
        d = 1;
        m = m % 12 + 1;
        if (m == 1) y++;
      end
      else d++;
      bus(1'b0, 6'h18, 32'h0);
      cmp("date word", dateW(y, m, d), rd);
    end
    bus(1'b1, 6'h10, 32'h1000_0000);
    bus(1'b1, 6'h14, 32'h1000_0008);
    for (int i = 0; i < 600 && alarmToCpu !== 1'b1; i++) @(posedge clk_sys);
    bus(1'b0, 6'h1c, 32'h0);
    cmp("alarm second", 32'h8, {26'h0, rd[5:0]});
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 6'h10, al0[k]);
      bus(1'b1, 6'h14, al1[k]);
      // Old alarm setup lingers until the crossing completes
      repeat (80) @(posedge clk_sys);
      n = 0;
      repeat (1300) begin
        @(posedge clk_sys);
        if ({alarmToCpu, alarmRing, alarmXtal} === 3'b111) n++;
      end
      cmp("alarm cycles", alN[k], n);
    end
    bus(1'b1, 6'h0c, 32'h0);
    wait_run(1'b0);
    bus(1'b0, 6'h1c, 32'h0);
    w = rd;
    repeat (100) @(posedge clk_sys);
    bus(1'b0, 6'h1c, 32'h0);
    cmp("stopped clock", w, rd);
    bus(1'b1, 6'h00, 32'h2);
    bus(1'b1, 6'h0c, 32'h1);
    wait_run(1'b1);
    bus(1'b0, 6'h1c, 32'h0);
    w = rd;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 100 && rd === w; i++) bus(1'b0, 6'h1c, 32'h0);
      w = rd;
      tk[k] = $time;
    end
    cmp("tick period", 32'h1, {31'h0, (tk[1] - tk[0] >= 285 && tk[1] - tk[0] <= 315)});
    summarize();
  end
endmodule : testbench

`default_nettype wire
